// ===== hw/lal_pkg.sv
/*
  Package for the latch acknowledge block: register indices, reset values
  and bit positions of the supervisory acknowledge register.
  Assumes a 32-bit plain register port with a 4-bit word address.
*/
package lal_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int DELAY_W = 16;

    // register word addresses
    localparam logic [3:0] REG_CTRL         = 4'h0;
    localparam logic [3:0] REG_IND_LATCH    = 4'h1;
    localparam logic [3:0] REG_RELAY_LATCH  = 4'h2;
    localparam logic [3:0] REG_SCADA_LATCH  = 4'h3;
    localparam logic [3:0] REG_TRIP_LATCH   = 4'h4;
    localparam logic [3:0] REG_OFF_DELAY    = 4'h5;
    localparam logic [3:0] REG_IND_STATE    = 4'h6;
    localparam logic [3:0] REG_RELAY_STATE  = 4'h7;
    localparam logic [3:0] REG_SCADA_STATE  = 4'h8;
    localparam logic [3:0] REG_TRIP_STATE   = 4'h9;
    localparam logic [3:0] REG_COMM_ACK     = 4'hA;

    // control register fields
    localparam int CTRL_PERMIT_BIT = 0;
    localparam logic RST_PERMIT = 1'b1;

    // supervisory acknowledge register fields (write-only, self clearing)
    localparam int COMM_IND_BIT   = 0;
    localparam int COMM_RELAY_BIT = 1;
    localparam int COMM_SCADA_BIT = 2;
    localparam int COMM_TRIP_BIT  = 3;

    // reset values
    localparam logic [31:0] RST_LATCH_EN  = 32'hFFFFFFFF;
    localparam logic [15:0] RST_OFF_DELAY = 16'h0000;
endpackage

// ===== hw/lal_edge.sv
/*
  Rising-edge detector for a vector of acknowledge sources.
  Assumes sources are synchronous to clock; the pulse comes one cycle late.
*/
`timescale 1ns/10ps
module lal_edge #(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] pulse
);
    logic [W-1:0] prev;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            prev  <= '0;
            pulse <= '0;
        end
        else
        begin
            prev  <= level;
            pulse <= level & ~prev;
        end
    end
endmodule

// ===== hw/lal_offdelay.sv
/*
  Off-delay timer for one output relay: counts the delay after a start
  pulse and gives a one-cycle done pulse. Assumes start only while idle.
*/
`timescale 1ns/10ps
module lal_offdelay #(
    parameter int DW = 16
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          start,
    input  wire logic          abort,
    input  wire logic [DW-1:0] delay,
    output logic               busy,
    output logic               done
);
    logic [DW-1:0] count;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            busy  <= 1'b0;
            done  <= 1'b0;
            count <= '0;
        end
        else if (abort)
        begin
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (start && !busy)
        begin
            busy  <= 1'b1;
            done  <= 1'b0;
            count <= delay;
        end
        else if (busy && count == '0)
        begin
            busy <= 1'b0;
            done <= 1'b1;
        end
        else
        begin
            done  <= 1'b0;
            count <= busy ? count - 1'b1 : count;
        end
    end
endmodule

// ===== hw/lal_top.sv
/*
  Latch acknowledge logic: latched indicators, relays, supervisory signals
  and trip commands, cleared singly or by group acknowledge sources.
  Assumes all inputs synchronous to clock and a plain register port.
*/
`timescale 1ns/10ps
module lal_top #(
    parameter int N_IND   = 16,
    parameter int N_SLOT  = 2,
    parameter int N_OUT   = 4,
    parameter int N_SG    = 2,
    parameter int N_SCADA = 8
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic [lal_pkg::ADDR_W-1:0] addr,
    input  wire logic [lal_pkg::DATA_W-1:0] wr_data,
    input  wire logic                       wr_stb,
    input  wire logic                       rd_stb,
    output logic      [lal_pkg::DATA_W-1:0] rd_data,
    input  wire logic [N_IND-1:0]           ind_set,
    input  wire logic [N_IND-1:0]           ind_clear_source,
    input  wire logic [N_SLOT*N_OUT-1:0]    relay_set,
    input  wire logic [N_SLOT*N_OUT-1:0]    relay_clear_source,
    input  wire logic [N_SG-1:0]            trip_set,
    input  wire logic [N_SG-1:0]            trip_clear_source,
    input  wire logic [N_SCADA-1:0]         scada_set,
    input  wire logic                       all_indicator_clear_source,
    input  wire logic                       all_relay_clear_source,
    input  wire logic                       all_scada_clear_source,
    output logic      [N_IND-1:0]           ind_out,
    output logic      [N_SLOT*N_OUT-1:0]    relay_out,
    output logic      [N_SG-1:0]            trip_out,
    output logic      [N_SCADA-1:0]         scada_out
);
    localparam int NR = N_SLOT * N_OUT;
    localparam int NS = N_IND + NR + N_SG + 3;

    logic                          permit;
    logic [N_IND-1:0]              ind_en;
    logic [NR-1:0]                 relay_en;
    logic [N_SCADA-1:0]            scada_en;
    logic [N_SG-1:0]               trip_en;
    logic [lal_pkg::DELAY_W-1:0]   off_delay;
    logic [3:0]                    comm_ack;
    logic [NS-1:0]                 src_pulse;
    logic [N_IND-1:0]              ind_src_p;
    logic [NR-1:0]                 relay_src_p;
    logic [N_SG-1:0]               trip_src_p;
    logic                          all_ind_p;
    logic                          all_relay_p;
    logic                          all_scada_p;
    logic [N_IND-1:0]              ind_clr;
    logic [NR-1:0]                 relay_clr;
    logic [N_SG-1:0]               trip_clr;
    logic [N_SCADA-1:0]            scada_clr;
    logic [NR-1:0]                 tmr_start;
    logic [NR-1:0]                 tmr_busy;
    logic [NR-1:0]                 tmr_done;
    logic [lal_pkg::DATA_W-1:0]    next_rd_data;

    // all assigned sources pass one edge detector
    lal_edge #(
        .W (NS)
    ) u_edge (
        .clock (clock),
        .rst_n (rst_n),
        .level ({all_scada_clear_source, all_relay_clear_source,
                 all_indicator_clear_source, trip_clear_source,
                 relay_clear_source, ind_clear_source}),
        .pulse (src_pulse)
    );

    assign ind_src_p   = src_pulse[N_IND-1:0];
    assign relay_src_p = src_pulse[N_IND+NR-1:N_IND];
    assign trip_src_p  = src_pulse[N_IND+NR+N_SG-1:N_IND+NR];
    assign all_ind_p   = src_pulse[NS-3];
    assign all_relay_p = src_pulse[NS-2];
    assign all_scada_p = src_pulse[NS-1];

    // clear requests, all gated by the remote permit
    always_comb
    begin
        ind_clr   = '0;
        relay_clr = '0;
        trip_clr  = '0;
        scada_clr = '0;
        if (permit)
        begin
            ind_clr   = ind_src_p | {N_IND{all_ind_p}}
                      | {N_IND{comm_ack[lal_pkg::COMM_IND_BIT]}};
            relay_clr = relay_src_p | {NR{all_relay_p}}
                      | {NR{comm_ack[lal_pkg::COMM_RELAY_BIT]}};
            trip_clr  = trip_src_p
                      | {N_SG{comm_ack[lal_pkg::COMM_TRIP_BIT]}};
            scada_clr = {N_SCADA{all_scada_p}}
                      | {N_SCADA{comm_ack[lal_pkg::COMM_SCADA_BIT]}};
        end
    end

    // set term always wins, so an active set line blocks the clear
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ind_out   <= '0;
            trip_out  <= '0;
            scada_out <= '0;
        end
        else
        begin
            ind_out   <= ind_set | (ind_out & ind_en & ~ind_clr);
            trip_out  <= trip_set | (trip_out & trip_en & ~trip_clr);
            scada_out <= scada_set | (scada_out & scada_en & ~scada_clr);
        end
    end

    // relay acknowledge starts the off-delay; latch falls on its end
    assign tmr_start = relay_clr & relay_out & relay_en & ~relay_set;

    genvar g;
    generate
        for (g = 0; g < NR; g++)
        begin : g_relay
            lal_offdelay #(
                .DW (lal_pkg::DELAY_W)
            ) u_tmr (
                .clock (clock),
                .rst_n (rst_n),
                .start (tmr_start[g]),
                .abort (relay_set[g]),
                .delay (off_delay),
                .busy  (tmr_busy[g]),
                .done  (tmr_done[g])
            );
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            relay_out <= '0;
        else
            relay_out <= relay_set | (relay_out & relay_en & ~tmr_done);
    end

    // register writes
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            permit    <= lal_pkg::RST_PERMIT;
            ind_en    <= N_IND'(lal_pkg::RST_LATCH_EN);
            relay_en  <= NR'(lal_pkg::RST_LATCH_EN);
            scada_en  <= N_SCADA'(lal_pkg::RST_LATCH_EN);
            trip_en   <= N_SG'(lal_pkg::RST_LATCH_EN);
            off_delay <= lal_pkg::RST_OFF_DELAY;
        end
        else if (wr_stb)
        begin
            case (addr)
                lal_pkg::REG_CTRL:        permit    <= wr_data[lal_pkg::CTRL_PERMIT_BIT];
                lal_pkg::REG_IND_LATCH:   ind_en    <= wr_data[N_IND-1:0];
                lal_pkg::REG_RELAY_LATCH: relay_en  <= wr_data[NR-1:0];
                lal_pkg::REG_SCADA_LATCH: scada_en  <= wr_data[N_SCADA-1:0];
                lal_pkg::REG_TRIP_LATCH:  trip_en   <= wr_data[N_SG-1:0];
                lal_pkg::REG_OFF_DELAY:   off_delay <= wr_data[lal_pkg::DELAY_W-1:0];
                default:                  permit    <= permit;
            endcase
        end
    end

    // supervisory acknowledge: one-cycle pulse per written bit
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            comm_ack <= 4'h0;
        else if (wr_stb && addr == lal_pkg::REG_COMM_ACK)
            comm_ack <= wr_data[3:0];
        else
            comm_ack <= 4'h0;
    end

    // register reads, data in the following cycle
    always_comb
    begin
        next_rd_data = '0;
        case (addr)
            lal_pkg::REG_CTRL:        next_rd_data[lal_pkg::CTRL_PERMIT_BIT] = permit;
            lal_pkg::REG_IND_LATCH:   next_rd_data[N_IND-1:0]   = ind_en;
            lal_pkg::REG_RELAY_LATCH: next_rd_data[NR-1:0]      = relay_en;
            lal_pkg::REG_SCADA_LATCH: next_rd_data[N_SCADA-1:0] = scada_en;
            lal_pkg::REG_TRIP_LATCH:  next_rd_data[N_SG-1:0]    = trip_en;
            lal_pkg::REG_OFF_DELAY:   next_rd_data[lal_pkg::DELAY_W-1:0] = off_delay;
            lal_pkg::REG_IND_STATE:   next_rd_data[N_IND-1:0]   = ind_out;
            lal_pkg::REG_RELAY_STATE: next_rd_data[NR-1:0]      = relay_out;
            lal_pkg::REG_SCADA_STATE: next_rd_data[N_SCADA-1:0] = scada_out;
            lal_pkg::REG_TRIP_STATE:  next_rd_data[N_SG-1:0]    = trip_out;
            default:                  next_rd_data = '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rd_data <= '0;
        else if (rd_stb)
            rd_data <= next_rd_data;
        else
            rd_data <= '0;
    end

    // assertions cover every channel of a group, not only the first
    a_ind_single_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (permit && (ind_src_p & ~ind_set) != '0)
        |=> ((ind_out & $past(ind_src_p & ~ind_set)) == '0))
        else $error("indicator not cleared by its own source");

    a_relay_single_ack: assert property (@(posedge clock) disable iff (!rst_n)
        (permit && (relay_src_p & relay_out & relay_en & ~relay_set & ~tmr_busy) != '0)
        |=> ((tmr_busy & $past(relay_src_p & relay_out & relay_en & ~relay_set & ~tmr_busy))
             == $past(relay_src_p & relay_out & relay_en & ~relay_set & ~tmr_busy)))
        else $error("relay acknowledge did not start its off-delay");

    a_trip_unit_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (permit && (trip_src_p & ~trip_set) != '0)
        |=> ((trip_out & $past(trip_src_p & ~trip_set)) == '0))
        else $error("trip command not cleared by its unit source");

    a_trip_comm_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (permit && comm_ack[lal_pkg::COMM_TRIP_BIT] && trip_set == '0) |=> trip_out == '0)
        else $error("supervisory trip acknowledge incomplete");

    a_permit_blocks_ind: assert property (@(posedge clock) disable iff (!rst_n)
        !permit |=> ((($past(ind_out & ind_en) & ~ind_out) == '0)
                     && (($past(trip_out & trip_en) & ~trip_out) == '0)
                     && (($past(scada_out & scada_en) & ~scada_out) == '0)))
        else $error("latch cleared without permit");

    a_permit_blocks_comm: assert property (@(posedge clock) disable iff (!rst_n)
        (!permit && comm_ack != 4'h0)
        |=> ((($past(scada_out & scada_en) & ~scada_out) == '0)
             && (($past(trip_out & trip_en) & ~trip_out) == '0)))
        else $error("supervisory request acted without permit");

    a_group_relay_ack: assert property (@(posedge clock) disable iff (!rst_n)
        (permit && all_relay_p)
        |=> ((tmr_busy & $past(relay_out & relay_en & ~relay_set & ~tmr_busy))
             == $past(relay_out & relay_en & ~relay_set & ~tmr_busy)))
        else $error("group relay acknowledge missed a relay");

    a_group_ind_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (permit && all_ind_p && ind_set == '0) |=> ind_out == '0)
        else $error("group indicator acknowledge incomplete");

    a_group_scada_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (permit && all_scada_p && scada_set == '0) |=> scada_out == '0)
        else $error("group supervisory acknowledge incomplete");

    a_set_holds_latch: assert property (@(posedge clock) disable iff (!rst_n)
        (ind_set != '0 || relay_set != '0)
        |=> (((ind_out & $past(ind_set)) == $past(ind_set))
             && ((relay_out & $past(relay_set)) == $past(relay_set))))
        else $error("latch cleared while its set signal active");

    a_set_holds_trip: assert property (@(posedge clock) disable iff (!rst_n)
        (trip_set != '0 || scada_set != '0)
        |=> (((trip_out & $past(trip_set)) == $past(trip_set))
             && ((scada_out & $past(scada_set)) == $past(scada_set))))
        else $error("trip or supervisory latch cleared while set");

    a_relay_after_delay: assert property (@(posedge clock) disable iff (!rst_n)
        (($past(relay_out & relay_en & ~tmr_done) & ~relay_out) == '0))
        else $error("relay released before off-delay end");

    a_relay_set_abort: assert property (@(posedge clock) disable iff (!rst_n)
        (relay_set != '0) |=> ((tmr_busy & $past(relay_set)) == '0))
        else $error("relay set did not stop its off-delay");

    a_edge_only_ack: assert property (@(posedge clock) disable iff (!rst_n)
        all_ind_p |-> ($past(all_indicator_clear_source)
                       && !$past(all_indicator_clear_source, 2)))
        else $error("group indicator pulse without rising edge");

    a_relay_edge_only: assert property (@(posedge clock) disable iff (!rst_n)
        all_relay_p |-> ($past(all_relay_clear_source)
                         && !$past(all_relay_clear_source, 2)))
        else $error("group relay pulse without rising edge");

    a_scada_edge_only: assert property (@(posedge clock) disable iff (!rst_n)
        all_scada_p |-> ($past(all_scada_clear_source)
                         && !$past(all_scada_clear_source, 2)))
        else $error("group supervisory pulse without rising edge");
endmodule

// ===== bench/lal_far_side.sv
/*
  Far-side model: protection set signals and acknowledge sources.
  Assumes one calling process and the block's clock; drives after edges.
*/
`timescale 1ns/10ps
module lal_far_side (
    input  wire logic        clock,
    output logic      [15:0] ind_set,
    output logic      [15:0] ind_clear_source,
    output logic      [7:0]  relay_set,
    output logic      [7:0]  relay_clear_source,
    output logic      [1:0]  trip_set,
    output logic      [1:0]  trip_clear_source,
    output logic      [7:0]  scada_set,
    output logic             all_indicator_clear_source,
    output logic             all_relay_clear_source,
    output logic             all_scada_clear_source
);
    initial
    begin
        {ind_set, ind_clear_source, relay_set, relay_clear_source} = '0;
        {trip_set, trip_clear_source, scada_set} = '0;
        {all_indicator_clear_source, all_relay_clear_source} = '0;
        all_scada_clear_source = 1'b0;
    end

    // groups 0..3 set lines, 10..12 single sources, 14..16 group sources
    task automatic put(input int g, input int i, input logic v);
        case (g)
            0: ind_set[i] <= v;
            1: relay_set[i] <= v;
            2: trip_set[i] <= v;
            3: scada_set[i] <= v;
            10: ind_clear_source[i] <= v;
            11: relay_clear_source[i] <= v;
            12: trip_clear_source[i] <= v;
            14: all_indicator_clear_source <= v;
            15: all_relay_clear_source <= v;
            default: all_scada_clear_source <= v;
        endcase
    endtask

    // one-cycle high, so the next hit is a fresh rising edge
    task automatic hit(input int g, input int i);
        @(posedge clock);
        put(g, i, 1'b1);
        @(posedge clock);
        put(g, i, 1'b0);
    endtask
endmodule

// ===== bench/tb_top.sv
/*
  Self-checking bench for the latch acknowledge block.
  Assumes the far-side model drives set and source lines; bench owns the bus.
*/
`timescale 1ns/10ps
module tb_top;
    logic        clock, rst_n, wr_stb, rd_stb;
    logic [3:0]  addr;
    logic [31:0] wr_data, rd_data, v;
    logic [15:0] ind_set, ind_clear_source, ind_out;
    logic [7:0]  relay_set, relay_clear_source, relay_out, scada_set, scada_out;
    logic [1:0]  trip_set, trip_clear_source, trip_out;
    logic        all_indicator_clear_source, all_relay_clear_source, all_scada_clear_source;
    int          err_total, n_compared;

    lal_far_side p (
        .clock(clock), .ind_set(ind_set), .ind_clear_source(ind_clear_source),
        .relay_set(relay_set), .relay_clear_source(relay_clear_source),
        .trip_set(trip_set), .trip_clear_source(trip_clear_source), .scada_set(scada_set),
        .all_indicator_clear_source(all_indicator_clear_source),
        .all_relay_clear_source(all_relay_clear_source),
        .all_scada_clear_source(all_scada_clear_source)
    );

    lal_top #(.N_IND(16), .N_SLOT(2), .N_OUT(4), .N_SG(2), .N_SCADA(8)) dut (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .ind_set(ind_set),
        .ind_clear_source(ind_clear_source), .relay_set(relay_set),
        .relay_clear_source(relay_clear_source), .trip_set(trip_set),
        .trip_clear_source(trip_clear_source), .scada_set(scada_set),
        .all_indicator_clear_source(all_indicator_clear_source),
        .all_relay_clear_source(all_relay_clear_source),
        .all_scada_clear_source(all_scada_clear_source), .ind_out(ind_out),
        .relay_out(relay_out), .trip_out(trip_out), .scada_out(scada_out)
    );

    always #25 clock = ~clock;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        d = rd_data;
    endtask

    // settle after n edges
    task automatic w(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        give_verdict();
    end

    initial
    begin
        {clock, rst_n, wr_stb, rd_stb, addr, wr_data} = '0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd(lal_pkg::REG_CTRL, v);
        check("permit", v, 32'h00000001);
        rd(4'hB, v);
        check("unmapped", v, 32'h00000000);
        $display("test reset done");

        p.hit(0, 3);
        p.hit(0, 5);
        p.hit(10, 3);
        w(2);
        check("ind single", ind_out, 32'h00000020);
        @(posedge clock);
        p.put(10, 5, 1'b1);
        w(3);
        check("ind held src", ind_out, 32'h00000000);
        p.hit(0, 5);
        w(3);
        check("ind no repeat", ind_out, 32'h00000020);
        @(posedge clock);
        p.put(10, 5, 1'b0);
        $display("test single indicator done");

        p.hit(0, 1);
        @(posedge clock);
        p.put(0, 0, 1'b1);
        p.hit(14, 0);
        w(3);
        check("ind set blocks", ind_out, 32'h00000001);
        @(posedge clock);
        p.put(0, 0, 1'b0);
        p.hit(14, 0);
        w(3);
        check("ind group", ind_out, 32'h00000000);
        $display("test indicator group done");

        p.hit(2, 0);
        p.hit(2, 1);
        p.hit(12, 1);
        w(2);
        check("trip unit", trip_out, 32'h00000001);
        wr(lal_pkg::REG_OFF_DELAY, 32'h00000003);
        p.hit(1, 6);
        p.hit(1, 2);
        p.hit(11, 6);
        w(5);
        check("relay delay", relay_out, 32'h00000044);
        w(4);
        check("relay single", relay_out, 32'h00000004);
        p.hit(1, 7);
        p.hit(15, 0);
        w(9);
        check("relay group", relay_out, 32'h00000000);
        p.hit(3, 0);
        p.hit(3, 7);
        w(1);
        check("scada set", scada_out, 32'h00000081);
        p.hit(16, 0);
        w(2);
        check("scada group", scada_out, 32'h00000000);
        $display("test groups done");

        wr(lal_pkg::REG_CTRL, 32'h00000000);
        p.hit(0, 2);
        p.hit(1, 1);
        p.hit(3, 4);
        p.hit(10, 2);
        p.hit(14, 0);
        p.hit(15, 0);
        wr(lal_pkg::REG_COMM_ACK, 32'h0000000F);
        w(12);
        check("ind no permit", ind_out, 32'h00000004);
        check("relay no permit", relay_out, 32'h00000002);
        check("scada no permit", scada_out, 32'h00000010);
        check("trip no permit", trip_out, 32'h00000001);
        wr(lal_pkg::REG_CTRL, 32'h00000001);
        wr(lal_pkg::REG_IND_STATE, 32'h00000000);
        rd(lal_pkg::REG_IND_STATE, v);
        check("ind state", v, 32'h00000004);
        wr(lal_pkg::REG_COMM_ACK, 32'h00000001 << lal_pkg::COMM_IND_BIT);
        w(3);
        check("comm ind", ind_out, 32'h00000000);
        wr(lal_pkg::REG_COMM_ACK, 32'h0000000E);
        w(12);
        check("comm relay", relay_out, 32'h00000000);
        check("comm scada", scada_out, 32'h00000000);
        check("comm trip", trip_out, 32'h00000000);
        rd(lal_pkg::REG_OFF_DELAY, v);
        check("off delay", v, 32'h00000003);
        wr(lal_pkg::REG_IND_LATCH, 32'h0000FFFB);
        rd(lal_pkg::REG_IND_LATCH, v);
        check("ind latch en", v, 32'h0000FFFB);
        p.hit(0, 2);
        w(1);
        check("ind no latch", ind_out, 32'h00000000);
        $display("test permit done");
        give_verdict();
    end
endmodule
